/* rtl/cbcis_pkg.sv */
// Constants, types and register map of the bus control and interrupt sequencer
package cbcis_pkg;
   // Machine cycle timing
   localparam int CLK_PERIOD_NS    = 25;
   localparam int MACHINE_CYCLE_NS = 1000;
   localparam int CYCLE_CLKS       = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W            = 6;
   localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(CYCLE_CLKS - 1);
   localparam logic [CNT_W-1:0] CNT_PHI2  = CNT_W'(CYCLE_CLKS / 2);
   localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

   // Vector locations, even address holds the high byte
   localparam logic [15:0] VEC_RESTART = 16'hfffe;
   localparam logic [15:0] VEC_NMI     = 16'hfffc;
   localparam logic [15:0] VEC_SWI     = 16'hfffa;
   localparam logic [15:0] VEC_IRQ     = 16'hfff8;
   localparam logic [15:0] VEC_LOW_BIT = 16'h0001;

   // Flags register layout
   localparam int          CCR_MASK_BIT = 4;
   localparam logic [7:0]  CCR_ONES     = 8'hc0;
   localparam logic [7:0]  CCR_RESET    = 8'hd0;

   // Stacking
   localparam logic [2:0]  STACK_LAST   = 3'h6;
   localparam logic [15:0] SP_STEP      = 16'h0001;

   // APB register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_PC     = 8'h04;
   localparam logic [7:0] OFF_SP     = 8'h08;
   localparam logic [7:0] OFF_IX     = 8'h0c;
   localparam logic [7:0] OFF_ACC    = 8'h10;
   localparam logic [7:0] OFF_CCR    = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   // Command field of the command register
   localparam int         CMD_GO_BIT = 0;
   localparam logic [1:0] KIND_PLAIN = 2'h0;
   localparam logic [1:0] KIND_WAIT  = 2'h1;
   localparam logic [1:0] KIND_SWI   = 2'h2;

   localparam int SYNC_W = 13;

   typedef enum logic [2:0] {
      ST_RUN, ST_STACK, ST_VEC_HI, ST_VEC_LO, ST_WAIT, ST_HALT
   } cbcis_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        addr_oe;
      logic        rw;
      logic        rw_oe;
      logic        address_valid;
      logic        bus_available;
      logic [7:0]  dout;
      logic        data_oe;
   } cbcis_bus_t;

   localparam cbcis_bus_t BUS_RESET = '{addr: 16'hffff, addr_oe: 1'b0, rw: 1'b1, rw_oe: 1'b0,
                                        address_valid: 1'b0, bus_available: 1'b0,
                                        dout: 8'h00, data_oe: 1'b0};
endpackage : cbcis_pkg

/* rtl/cbcis_top.sv */
// Bus control, halt, bus release and interrupt sequencer with APB register access
//
// The APB slave port and the address map were decided locally.

module cbcis_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // Reset every stage to all ones; reset_val is not used
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cbcis_sync

module cbcis_top
   import cbcis_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Control pins
   input  wire logic        halt_n,
   input  wire logic        irq_n,
   input  wire logic        nmi_n,
   input  wire logic        bus_float_control,
   input  wire logic        data_drive_enable,
   // Bus pins
   input  wire logic [7:0]  data_lines_in,
   output cbcis_bus_t       bus_q
);
   cbcis_state_t     state_q, state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [2:0]       idx_q;
   logic [15:0]      vec_q, vec_d, pc_q, sp_q, ix_q;
   logic [7:0]       acc_a_q, acc_b_q, ccr_q;
   logic             nmi_pend_q, irq_lat_q, nmi_prev_q, go_q;
   logic [1:0]       kind_q;
   logic [SYNC_W-1:0] sync_s;
   cbcis_bus_t       bus_d;

   // Synchronised pins
   logic       halt_s, irq_s, nmi_s, float_s, dde_s;
   logic [7:0] din_s;

   cbcis_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk       (pclk),
      .rst_n     (presetn),
      .async_in  ({halt_n, irq_n, nmi_n, bus_float_control, data_drive_enable, data_lines_in}),
      .reset_val ('1),
      .sync_out  (sync_s)
   );
   assign {halt_s, irq_s, nmi_s, float_s, dde_s, din_s} = sync_s;

   // Machine cycle divider; floating holds the count in phase one
   wire phi2_start = (cnt_q == CNT_PHI2);
   wire cycle_end  = (cnt_q == CNT_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= CNT_ZERO;
      else if (float_s) cnt_q <= CNT_ZERO;
      else if (cycle_end) cnt_q <= CNT_ZERO;
      else cnt_q <= cnt_q + CNT_W'(1);
   end

   // APB decode
   wire apb_acc   = psel & penable & ~pready;
   // Write lands on the edge where the master sees pready high
   wire apb_wr    = psel & penable & pready & pwrite;
   wire hit_cmd   = (paddr == OFF_CMD);
   wire hit_pc    = (paddr == OFF_PC);
   wire hit_sp    = (paddr == OFF_SP);
   wire hit_ix    = (paddr == OFF_IX);
   wire hit_acc   = (paddr == OFF_ACC);
   wire hit_ccr   = (paddr == OFF_CCR);
   wire hit_stat  = (paddr == OFF_STATUS);
   wire mapped    = hit_cmd | hit_pc | hit_sp | hit_ix | hit_acc | hit_ccr | hit_stat;
   wire [31:0] status_w = {25'h0, go_q, irq_lat_q, nmi_pend_q, 1'b0, state_q};
   wire [31:0] rd_mux =
      hit_pc   ? {16'h0, pc_q} :
      hit_sp   ? {16'h0, sp_q} :
      hit_ix   ? {16'h0, ix_q} :
      hit_acc  ? {16'h0, acc_b_q, acc_a_q} :
      hit_ccr  ? {24'h0, ccr_q | CCR_ONES} :
      hit_stat ? status_w : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= apb_acc;
         pslverr <= apb_acc & ~mapped;
         prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   // Interrupt sampling in phase two
   wire mask_set  = ccr_q[CCR_MASK_BIT];
   wire irq_take  = irq_lat_q & ~mask_set;
   wire nmi_fall  = phi2_start & nmi_prev_q & ~nmi_s;
   wire step      = cycle_end & ~float_s;
   wire go_step   = step & (state_q == ST_RUN) & halt_s & go_q;
   wire svc_nmi   = step & (state_d == ST_STACK) & (state_q != ST_STACK) & (vec_d == VEC_NMI);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_prev_q <= 1'b1;
         nmi_pend_q <= 1'b0;
         irq_lat_q  <= 1'b0;
      end else begin
         if (phi2_start) nmi_prev_q <= nmi_s;
         // New edge beats the clear of the old one
         if (nmi_fall) nmi_pend_q <= 1'b1;
         else if (svc_nmi) nmi_pend_q <= 1'b0;
         // Level request; kept while halted so it is seen afterwards
         if (phi2_start && (!irq_s || halt_s)) irq_lat_q <= ~irq_s;
      end
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      vec_d   = vec_q;
      case (state_q)
         ST_RUN: begin
            if (!halt_s) state_d = ST_HALT;
            else if (go_q) begin
               if (kind_q == KIND_SWI) begin
                  state_d = ST_STACK;
                  vec_d   = VEC_SWI;
               end else if (nmi_pend_q) begin
                  state_d = ST_STACK;
                  vec_d   = VEC_NMI;
               end else if (irq_take) begin
                  state_d = ST_STACK;
                  vec_d   = VEC_IRQ;
               end else if (kind_q == KIND_WAIT) state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (nmi_pend_q) begin
               state_d = ST_STACK;
               vec_d   = VEC_NMI;
            end else if (irq_take) begin
               state_d = ST_STACK;
               vec_d   = VEC_IRQ;
            end
         end
         ST_HALT:   if (halt_s) state_d = ST_RUN;
         ST_STACK:  if (idx_q == STACK_LAST) state_d = ST_VEC_HI;
         ST_VEC_HI: state_d = ST_VEC_LO;
         ST_VEC_LO: state_d = ST_RUN;
         default:   state_d = ST_RUN;
      endcase
   end

   // Sequencer state; restart vector fetch straight after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_VEC_HI;
         vec_q   <= VEC_RESTART;
         idx_q   <= 3'h0;
      end else if (step) begin
         state_q <= state_d;
         vec_q   <= vec_d;
         idx_q   <= (state_q == ST_STACK) ? idx_q + 3'h1 : 3'h0;
      end
   end

   // Command pending from software marks instruction completion
   wire go_wr = apb_wr & hit_cmd & pwdata[CMD_GO_BIT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_q   <= 1'b0;
         kind_q <= KIND_PLAIN;
      end else if (go_wr) begin
         go_q   <= 1'b1;
         kind_q <= pwdata[2:1];
      end else if (go_step) go_q <= 1'b0;
   end

   // Programmer registers; sequencer updates take priority over software
   wire vec_hi_ld = step & (state_q == ST_VEC_HI);
   wire vec_lo_ld = step & (state_q == ST_VEC_LO);
   wire stack_wr  = step & (state_q == ST_STACK);
   wire stack_end = stack_wr & (idx_q == STACK_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q    <= 16'h0000;
         sp_q    <= 16'h0000;
         ix_q    <= 16'h0000;
         acc_a_q <= 8'h00;
         acc_b_q <= 8'h00;
         ccr_q   <= CCR_RESET;
      end else begin
         if (vec_hi_ld) pc_q[15:8] <= din_s;
         else if (vec_lo_ld) pc_q[7:0] <= din_s;
         else if (apb_wr && hit_pc) pc_q <= pwdata[15:0];
         if (stack_wr) sp_q <= sp_q - SP_STEP;
         else if (apb_wr && hit_sp) sp_q <= pwdata[15:0];
         if (apb_wr && hit_ix) ix_q <= pwdata[15:0];
         if (apb_wr && hit_acc) begin
            acc_a_q <= pwdata[7:0];
            acc_b_q <= pwdata[15:8];
         end
         if (stack_end) ccr_q[CCR_MASK_BIT] <= 1'b1;
         else if (apb_wr && hit_ccr) ccr_q <= pwdata[7:0] | CCR_ONES;
      end
   end

   // Byte pushed in each stacking cycle
   logic [7:0] stack_byte;
   always_comb begin
      case (idx_q)
         3'h0:    stack_byte = pc_q[7:0];
         3'h1:    stack_byte = pc_q[15:8];
         3'h2:    stack_byte = ix_q[7:0];
         3'h3:    stack_byte = ix_q[15:8];
         3'h4:    stack_byte = acc_a_q;
         3'h5:    stack_byte = acc_b_q;
         default: stack_byte = ccr_q | CCR_ONES;
      endcase
   end

   // Pin drive per state
   wire stopped = (state_q == ST_HALT) | (state_q == ST_WAIT);
   wire vec_cyc = (state_q == ST_VEC_HI) | (state_q == ST_VEC_LO);
   wire wr_cyc  = (state_q == ST_STACK);
   wire [15:0] vec_addr = (state_q == ST_VEC_LO) ? (vec_q | VEC_LOW_BIT) : vec_q;

   always_comb begin
      bus_d               = BUS_RESET;
      bus_d.addr          = wr_cyc ? sp_q : (vec_cyc ? vec_addr : pc_q);
      bus_d.addr_oe       = ~stopped & ~float_s;
      bus_d.rw            = ~wr_cyc;
      bus_d.rw_oe         = ~stopped & ~float_s;
      bus_d.address_valid = (wr_cyc | vec_cyc) & ~float_s;
      bus_d.bus_available = stopped & ~float_s;
      bus_d.dout          = stack_byte;
      // Drivers off in reads whatever the enable pin says
      bus_d.data_oe       = dde_s & wr_cyc & ~stopped;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bus_q <= BUS_RESET;
      else bus_q <= bus_d;
   end
endmodule : cbcis_top

/* sim/cbcis_mem_model.sv */
// Memory and peripheral side of the processor bus
module cbcis_mem_model
   import cbcis_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Content seed and bus
   input  wire logic [7:0] key,
   input  wire cbcis_bus_t bus_q,
   output logic      [7:0] data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sel;
   // Select only on a valid, driven read address
   assign sel = bus_q.address_valid && bus_q.rw && bus_q.addr_oe;
   // Released bus toggles so a stale byte is never mistaken for data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) data_out <= 8'h00;
      else if (sel) data_out <= bus_q.addr[7:0] ^ key;
      else data_out <= ~data_out;
   end
endmodule : cbcis_mem_model

/* sim/cbcis_properties.sv */
// Bus control assertions of the sequencer
module cbcis_chk
   import cbcis_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       halt_n,
   input  wire logic       bus_float_control,
   input  wire cbcis_bus_t bus_q
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] halt_cnt_q;
   // Halt may wait out a whole interrupt sequence before stopping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) halt_cnt_q <= 9'h000;
      else if (halt_n || bus_float_control) halt_cnt_q <= 9'h000;
      else if (halt_cnt_q != 9'h1ff) halt_cnt_q <= halt_cnt_q + 9'h001;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_float_drops_bus: assert property (bus_float_control [*5] |-> !bus_q.addr_oe &&
      !bus_q.rw_oe && !bus_q.address_valid && !bus_q.bus_available)
      else $error("bus float did not release the bus");
   a_halt_stops_bus: assert property (halt_cnt_q >= 9'h1e0 |-> bus_q.bus_available &&
      !bus_q.address_valid && !bus_q.addr_oe && !bus_q.rw_oe && !bus_q.data_oe)
      else $error("halt did not stop the bus");
   a_write_qualified: assert property (!bus_q.rw |-> bus_q.rw_oe && bus_q.address_valid)
      else $error("write level without valid driven address");
   a_no_drive_read: assert property (bus_q.data_oe |-> !bus_q.rw && bus_q.address_valid)
      else $error("data driven during a read");
   a_vector_pair: assert property ($changed(bus_q.addr) && bus_q.address_valid &&
      bus_q.addr[15:3] == 13'h1fff && !bus_q.addr[0] |-> ##[1:80]
      (bus_q.address_valid && bus_q.addr[0] && bus_q.addr[15:3] == 13'h1fff))
      else $error("vector low byte fetch missing");
   a_restart_first: assert property ($rose(presetn) |-> ##[1:90]
      (bus_q.addr == VEC_RESTART && bus_q.address_valid && bus_q.rw))
      else $error("restart vector fetch missing");
   a_valid_driven: assert property (bus_q.address_valid |-> bus_q.addr_oe)
      else $error("valid address with address floated");
   a_ba_stopped: assert property (bus_q.bus_available |-> !bus_q.address_valid &&
      !bus_q.addr_oe && !bus_q.rw_oe && !bus_q.data_oe)
      else $error("bus available while driving");
endmodule : cbcis_chk

bind cbcis_top cbcis_chk chk_u (.pclk(pclk), .presetn(presetn), .halt_n(halt_n),
   .bus_float_control(bus_float_control), .bus_q(bus_q));

/* sim/tb_top.sv */
// Self-checking bench of the bus control and interrupt sequencer
module tb_top
   import cbcis_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        halt_n, irq_n, nmi_n, bus_float_control, data_drive_enable;
   logic [7:0]  paddr, data_lines_in, key;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] sp;
   logic [7:0]  pushed;
   cbcis_bus_t  bus_q;
   int          seed = 89636;
   int          error_cnt = 0;
   int          checked = 0;

   cbcis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_n(halt_n), .irq_n(irq_n), .nmi_n(nmi_n),
      .bus_float_control(bus_float_control), .data_drive_enable(data_drive_enable),
      .data_lines_in(data_lines_in), .bus_q(bus_q));
   cbcis_mem_model mem_u (.pclk(pclk), .presetn(presetn), .key(key), .bus_q(bus_q),
      .data_out(data_lines_in));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Data enable is random but held low while another master owns the bus
   always @(posedge pclk) data_drive_enable <= bus_float_control ? 1'b0 : 1'($random(seed));
   // Flags byte is the last push of the first stacking run
   always @(posedge pclk) begin
      if (!bus_q.rw && bus_q.address_valid && bus_q.addr == sp - 16'h0006) pushed <= bus_q.dout;
   end

   function automatic logic [31:0] vec(input logic [7:0] lo);
      return {16'h0000, (lo & 8'hfe) ^ key, (lo | 8'h01) ^ key};
   endfunction : vec
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer taken at the very edge where pready is sampled high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rd_chk
   task automatic st_chk(input cbcis_state_t s, input string what);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk({29'h0, rd[2:0]}, {29'h0, s}, what);
   endtask : st_chk
   task automatic wait_run();
      int n;
      n = 0;
      do begin
         repeat (20) @(posedge pclk);
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while ((rd[2:0] !== ST_RUN || rd[6] !== 1'b0) && n < 200);
      if (n >= 200) error_cnt++;
   endtask : wait_run
   task automatic cmd(input logic [1:0] kind);
      apb(1'b1, OFF_CMD, {29'h0, kind, 1'b1});
      wait_run();
   endtask : cmd
   task automatic wrap_up();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {halt_n, irq_n, nmi_n, bus_float_control} = 4'he;
      key = 8'($random(seed));
      sp = 16'h0100 + (16'($random(seed)) & 16'h0fff);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wait_run();
      rd_chk(OFF_PC, vec(VEC_RESTART[7:0]), "restart pc");
      rd_chk(OFF_CCR, {24'h0, CCR_RESET}, "reset ccr");
      rd_chk(8'h1c, 32'h0, "unmapped data");
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b1, OFF_SP, {16'h0, sp});
      irq_n <= 1'b0;
      cmd(KIND_PLAIN);
      rd_chk(OFF_PC, vec(VEC_RESTART[7:0]), "masked irq");
      apb(1'b1, OFF_CCR, 32'h0);
      rd_chk(OFF_CCR, {24'h0, CCR_ONES}, "ccr ones");
      cmd(KIND_PLAIN);
      irq_n <= 1'b1;
      rd_chk(OFF_PC, vec(VEC_IRQ[7:0]), "irq pc");
      rd_chk(OFF_SP, {16'h0, sp - 16'h0007}, "stack depth");
      chk({24'h0, pushed}, {24'h0, CCR_ONES}, "pushed flags");
      rd_chk(OFF_CCR, {24'h0, CCR_RESET}, "mask after irq");
      nmi_n <= 1'b0;
      // Edge must be latched before the instruction completes
      repeat (50) @(posedge pclk);
      cmd(KIND_PLAIN);
      nmi_n <= 1'b1;
      rd_chk(OFF_PC, vec(VEC_NMI[7:0]), "nmi pc");
      cmd(KIND_SWI);
      rd_chk(OFF_PC, vec(VEC_SWI[7:0]), "swi pc");
      apb(1'b1, OFF_CMD, {29'h0, KIND_WAIT, 1'b1});
      irq_n <= 1'b0;
      repeat (100) @(posedge pclk);
      st_chk(ST_WAIT, "wait held");
      irq_n <= 1'b1;
      nmi_n <= 1'b0;
      wait_run();
      nmi_n <= 1'b1;
      rd_chk(OFF_PC, vec(VEC_NMI[7:0]), "wait exit");
      halt_n <= 1'b0;
      repeat (100) @(posedge pclk);
      st_chk(ST_HALT, "halted");
      nmi_n <= 1'b0;
      repeat (420) @(posedge pclk);
      st_chk(ST_HALT, "nmi held off");
      halt_n <= 1'b1;
      repeat (40) @(posedge pclk);
      halt_n <= 1'b0;
      repeat (100) @(posedge pclk);
      st_chk(ST_HALT, "single step");
      halt_n <= 1'b1;
      nmi_n <= 1'b1;
      cmd(KIND_PLAIN);
      rd_chk(OFF_PC, vec(VEC_NMI[7:0]), "latched nmi");
      bus_float_control <= 1'b1;
      repeat (150) @(posedge pclk);
      bus_float_control <= 1'b0;
      wait_run();
      rd_chk(OFF_PC, vec(VEC_NMI[7:0]), "pc after float");
      wrap_up();
   end

   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      wrap_up();
   end
endmodule : tb_top
